// ### pkg/lpwr_pkg.sv
// Constants, offsets, fields and states for the power-mode and wake controller.
// Assumes a byte-addressed Avalon-MM slave with one 32-bit word per register.
package lpwr_pkg;
    localparam int AW = 8;
    localparam logic [7:0] OFS_PWR_CTRL = 8'h00;
    localparam logic [7:0] OFS_DPD_CTRL = 8'h04;
    localparam logic [7:0] OFS_START_PIN = 8'h08;
    localparam logic [7:0] OFS_START_PER = 8'h0C;
    localparam logic [7:0] OFS_FIXED_PIN = 8'h10;
    localparam logic [7:0] OFS_SLEEP_CFG = 8'h14;
    localparam logic [7:0] OFS_BOD_CTRL = 8'h18;
    localparam logic [7:0] OFS_WDT_MODE = 8'h1C;
    localparam logic [7:0] OFS_PER_CFG = 8'h20;
    localparam logic [7:0] OFS_CLK_CFG = 8'h24;
    localparam logic [7:0] OFS_WKT_COUNT = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_DSLEEP = 2'h1;
    localparam logic [1:0] MODE_PDOWN = 2'h2;
    localparam logic [1:0] MODE_DPD = 2'h3;
    // Field positions
    localparam int PC_LOCK = 2;
    localparam int DC_WAKE = 0, DC_RST = 1, DC_LPOSC = 2, DC_LPKEEP = 3;
    localparam int SC_BOD = 0, SC_WATCHDOG_OSC = 1;
    localparam int BC_INT = 0, BC_RST = 1;
    localparam int WM_EN = 0, WM_INT = 1, WM_RST = 2;
    localparam int PF_WKTLP = 0, PF_TCHWDO = 1, PF_TCHIE = 2, PF_SERIE = 3, PF_SERSLV = 4;
    localparam int SP_BOD = 0, SP_WDT = 1, SP_WKT = 2, SP_SER = 3, SP_TCH = 4;
    localparam int CK_FRO = 0, CK_FROOUT = 1, CK_FLASH = 2, CK_PLL = 3, CK_SYSTEM_OSC = 4;
    localparam int CK_ANALOG = 5, CK_DIGITAL = 6, CK_BOD = 7, CK_WATCHDOG_OSC = 8, CK_TOUCH = 9;
    localparam int CK_LPOSC = 10, CK_ALT = 11;
    localparam int ST_REFUSED = 3, ST_CAUSE = 4;
    localparam int WK_IRQ = 0, WK_RPIN = 1, WK_PIN = 2, WK_BODI = 3, WK_BODR = 4, WK_WDTI = 5;
    localparam int WK_WDTR = 6, WK_WKT = 7, WK_SER = 8, WK_TCH = 9, WK_WPIN = 10, WK_N = 11;
    localparam logic [11:0] CLK_CFG_RST = 12'h047;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SLEEP = 3'b001,
        ST_DSLEEP = 3'b010,
        ST_PDOWN = 3'b011,
        ST_DPD = 3'b100
    } pstate_t;
endpackage

// ### rtl/pwr_wake_ctrl.sv
// Power-mode controller: mode entry, clock/power gating, wake qualification.
// Assumes one 10 MHz clock, synchronous inputs and an Avalon-MM master.
// Function
// - Lock bit set blocks deep power-down entry.
// - Sleep keeps software setup; deep-sleep keeps oscillator, flash, BOD, watchdog, touch and low-power oscillator power, stops rest.
// - Power-down stops oscillator, flash; deep power-down keeps only wake pin logic and wake timer.
// - In sleep any enabled interrupt wakes the core.
// - Reset pin wakes sleep modes only if enabled in fixed-pin register.
// - Pin interrupts wake only with controller and start-logic enables.
// - Brownout interrupt needs three enables and detector powered.
// - Brownout reset needs reset enable and detector powered.
// - Watchdog interrupt needs enables, running watchdog, oscillator powered.
// - Watchdog reset needs running watchdog, reset enable, oscillator powered.
// - Wake timer wakes with enables, low-power clock; count write starts it.
// - Serial interrupts wake only enabled, slave mode, external clock supplied.
// - Touch interrupt needs enables, watchdog clock and touch event.
// - Wake pin exits deep power-down only when enabled.
// - Reset pin exits deep power-down only when enabled.
// - Wake timer exits deep power-down only with oscillator kept running.
// - Sleep stops core clock; reset or interrupt restarts it.
// - Deep power-down removes power except wake pin logic and timer.
// - After wake run from internal oscillator until software picks stable source.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
module pwr_wake_ctrl #(
    parameter int NIRQ = 32,
    parameter int NPIN = 8,
    parameter int WKT_W = 32
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic [lpwr_pkg::AW-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic CORE_SLEEP_REQ,
    input wire logic [NIRQ-1:0] IRQ_PENDING,
    input wire logic [NIRQ-1:0] IRQ_NESTED_INT_CTRL_EN,
    input wire logic [NPIN-1:0] PIN_INT,
    input wire logic [NPIN-1:0] PIN_NESTED_INT_CTRL_EN,
    input wire logic [4:0] PER_NESTED_INT_CTRL_EN,
    input wire logic BOD_INT,
    input wire logic BOD_RST,
    input wire logic WDT_INT,
    input wire logic WDT_RST,
    input wire logic WDT_FED,
    input wire logic SERIAL_INT,
    input wire logic SERIAL_EXT_CLK,
    input wire logic TOUCH_EVENT,
    input wire logic WAKE_PIN_N,
    input wire logic RESET_PIN_N,
    input wire logic ALT_CLK_STABLE,
    output logic CORE_CLK_EN,
    output logic FRO_EN,
    output logic FRO_OUT_EN,
    output logic FLASH_EN,
    output logic PLL_EN,
    output logic SYSTEM_OSC_EN,
    output logic ANALOG_EN,
    output logic DIGITAL_EN,
    output logic BOD_PWR,
    output logic WATCHDOG_OSC_PWR,
    output logic TOUCH_PWR,
    output logic LPOSC_PWR,
    output logic CHIP_PWR,
    output logic MAIN_CLK_ALT,
    output logic WAKE_RESET
);
    logic [2:0] pwr_ctrl_q;
    logic [3:0] dpd_ctrl_q;
    logic [NPIN-1:0] start_pin_q;
    logic [4:0] start_per_q;
    logic fixed_pin_q;
    logic [1:0] sleep_cfg_q, bod_ctrl_q;
    logic [2:0] wdt_mode_q;
    logic [4:0] per_cfg_q;
    logic [11:0] clk_cfg_q;
    logic [WKT_W-1:0] wkt_cnt_q, wkt_cnt_d;
    logic wkt_flag_q, refused_q, ack_q, wake_rst_q;
    logic [lpwr_pkg::WK_N-1:0] cause_q;
    logic [31:0] rdata_q, rd_mux;
    lpwr_pkg::pstate_t state_q, state_d;

    // Bus decode
    wire req = AVS_READ | AVS_WRITE;
    wire wr_acc = AVS_WRITE & ack_q;
    wire [31:0] bemask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                          {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    function automatic logic [31:0] upd(input logic [31:0] cur, input logic [31:0] wd,
                                        input logic [31:0] m);
        upd = (wd & m) | (cur & ~m);
    endfunction
    wire [31:0] wv_pc = upd({29'h0, pwr_ctrl_q}, AVS_WRITEDATA, bemask);
    wire [31:0] wv_dc = upd({28'h0, dpd_ctrl_q}, AVS_WRITEDATA, bemask);
    wire [31:0] wv_sp = upd(32'(start_pin_q), AVS_WRITEDATA, bemask);
    wire [31:0] wv_se = upd({27'h0, start_per_q}, AVS_WRITEDATA, bemask);
    wire [31:0] wv_fp = upd({31'h0, fixed_pin_q}, AVS_WRITEDATA, bemask);
    wire [31:0] wv_sc = upd({30'h0, sleep_cfg_q}, AVS_WRITEDATA, bemask);
    wire [31:0] wv_bc = upd({30'h0, bod_ctrl_q}, AVS_WRITEDATA, bemask);
    wire [31:0] wv_wm = upd({29'h0, wdt_mode_q}, AVS_WRITEDATA, bemask);
    wire [31:0] wv_pf = upd({27'h0, per_cfg_q}, AVS_WRITEDATA, bemask);
    wire [31:0] wv_ck = upd({20'h0, clk_cfg_q}, AVS_WRITEDATA, bemask);
    wire [31:0] wv_wk = upd(32'(wkt_cnt_q), AVS_WRITEDATA, bemask);
    wire we_pc = wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_PWR_CTRL);
    wire we_wk = wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_WKT_COUNT);
    wire we_st = wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_STATUS);
    wire [31:0] status = {17'h0, cause_q, refused_q, state_q};

    always_comb begin
        case (AVS_ADDRESS)
            lpwr_pkg::OFS_PWR_CTRL: rd_mux = {29'h0, pwr_ctrl_q};
            lpwr_pkg::OFS_DPD_CTRL: rd_mux = {28'h0, dpd_ctrl_q};
            lpwr_pkg::OFS_START_PIN: rd_mux = 32'(start_pin_q);
            lpwr_pkg::OFS_START_PER: rd_mux = {27'h0, start_per_q};
            lpwr_pkg::OFS_FIXED_PIN: rd_mux = {31'h0, fixed_pin_q};
            lpwr_pkg::OFS_SLEEP_CFG: rd_mux = {30'h0, sleep_cfg_q};
            lpwr_pkg::OFS_BOD_CTRL: rd_mux = {30'h0, bod_ctrl_q};
            lpwr_pkg::OFS_WDT_MODE: rd_mux = {29'h0, wdt_mode_q};
            lpwr_pkg::OFS_PER_CFG: rd_mux = {27'h0, per_cfg_q};
            lpwr_pkg::OFS_CLK_CFG: rd_mux = {20'h0, clk_cfg_q};
            lpwr_pkg::OFS_WKT_COUNT: rd_mux = 32'(wkt_cnt_q);
            lpwr_pkg::OFS_STATUS: rd_mux = status;
            default: rd_mux = 32'h0;
        endcase
    end

    // One wait cycle per access
    assign AVS_WAITREQUEST = req & ~ack_q;
    assign AVS_READDATA = rdata_q;
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= req & ~ack_q;
            if (AVS_READ & ~ack_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Wake qualification
    wire in_run = state_q == lpwr_pkg::ST_RUN;
    wire in_sleep = state_q == lpwr_pkg::ST_SLEEP;
    wire in_dpd = state_q == lpwr_pkg::ST_DPD;
    wire in_dspd = (state_q == lpwr_pkg::ST_DSLEEP) | (state_q == lpwr_pkg::ST_PDOWN);
    wire wdt_run = wdt_mode_q[lpwr_pkg::WM_EN] & WDT_FED;
    wire wkt_lp = per_cfg_q[lpwr_pkg::PF_WKTLP] & dpd_ctrl_q[lpwr_pkg::DC_LPOSC];
    wire wkt_exp = LPOSC_PWR & (wkt_cnt_q == WKT_W'(1));
    wire [lpwr_pkg::WK_N-1:0] src;
    assign src[lpwr_pkg::WK_IRQ] = |(IRQ_PENDING & IRQ_NESTED_INT_CTRL_EN);
    assign src[lpwr_pkg::WK_RPIN] = ~RESET_PIN_N & fixed_pin_q;
    assign src[lpwr_pkg::WK_PIN] = |(PIN_INT & PIN_NESTED_INT_CTRL_EN & start_pin_q);
    assign src[lpwr_pkg::WK_BODI] = BOD_INT & PER_NESTED_INT_CTRL_EN[lpwr_pkg::SP_BOD]
        & start_per_q[lpwr_pkg::SP_BOD] & bod_ctrl_q[lpwr_pkg::BC_INT]
        & sleep_cfg_q[lpwr_pkg::SC_BOD];
    assign src[lpwr_pkg::WK_BODR] = BOD_RST & bod_ctrl_q[lpwr_pkg::BC_RST]
        & sleep_cfg_q[lpwr_pkg::SC_BOD];
    assign src[lpwr_pkg::WK_WDTI] = WDT_INT & PER_NESTED_INT_CTRL_EN[lpwr_pkg::SP_WDT]
        & start_per_q[lpwr_pkg::SP_WDT] & wdt_mode_q[lpwr_pkg::WM_INT] & wdt_run
        & sleep_cfg_q[lpwr_pkg::SC_WATCHDOG_OSC];
    assign src[lpwr_pkg::WK_WDTR] = WDT_RST & wdt_run & wdt_mode_q[lpwr_pkg::WM_RST]
        & sleep_cfg_q[lpwr_pkg::SC_WATCHDOG_OSC];
    assign src[lpwr_pkg::WK_WKT] = wkt_flag_q & PER_NESTED_INT_CTRL_EN[lpwr_pkg::SP_WKT]
        & start_per_q[lpwr_pkg::SP_WKT] & wkt_lp;
    assign src[lpwr_pkg::WK_SER] = SERIAL_INT & PER_NESTED_INT_CTRL_EN[lpwr_pkg::SP_SER]
        & start_per_q[lpwr_pkg::SP_SER] & per_cfg_q[lpwr_pkg::PF_SERIE]
        & per_cfg_q[lpwr_pkg::PF_SERSLV] & SERIAL_EXT_CLK;
    assign src[lpwr_pkg::WK_TCH] = TOUCH_EVENT & PER_NESTED_INT_CTRL_EN[lpwr_pkg::SP_TCH]
        & start_per_q[lpwr_pkg::SP_TCH] & per_cfg_q[lpwr_pkg::PF_TCHIE]
        & per_cfg_q[lpwr_pkg::PF_TCHWDO];
    assign src[lpwr_pkg::WK_WPIN] = ~WAKE_PIN_N & dpd_ctrl_q[lpwr_pkg::DC_WAKE];
    wire dpd_rpin = ~RESET_PIN_N & dpd_ctrl_q[lpwr_pkg::DC_RST];
    wire dpd_wkt = wkt_flag_q & wkt_lp & dpd_ctrl_q[lpwr_pkg::DC_LPKEEP];
    wire [lpwr_pkg::WK_N-1:0] sel_sleep = (lpwr_pkg::WK_N)'(1 << lpwr_pkg::WK_IRQ)
        | (lpwr_pkg::WK_N)'(1 << lpwr_pkg::WK_RPIN);
    wire [lpwr_pkg::WK_N-1:0] sel_dspd = ~(lpwr_pkg::WK_N)'(1 << lpwr_pkg::WK_IRQ)
        & ~(lpwr_pkg::WK_N)'(1 << lpwr_pkg::WK_WPIN);
    wire [lpwr_pkg::WK_N-1:0] hit_dpd = {src[lpwr_pkg::WK_WPIN], 2'h0, dpd_wkt,
        5'h0, dpd_rpin, 1'b0};
    // Only sources valid for the present mode count
    wire [lpwr_pkg::WK_N-1:0] hit = in_sleep ? (src & sel_sleep)
        : in_dspd ? (src & sel_dspd) : in_dpd ? hit_dpd : '0;
    wire wake = |hit;
    wire rst_wake = hit[lpwr_pkg::WK_RPIN] | hit[lpwr_pkg::WK_BODR]
        | hit[lpwr_pkg::WK_WDTR] | in_dpd;
    wire dpd_block = pwr_ctrl_q[1:0] == lpwr_pkg::MODE_DPD & pwr_ctrl_q[lpwr_pkg::PC_LOCK];
    wire refuse = in_run & CORE_SLEEP_REQ & dpd_block;

    // Mode sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            lpwr_pkg::ST_RUN: begin
                if (CORE_SLEEP_REQ & ~dpd_block) begin
                    case (pwr_ctrl_q[1:0])
                        lpwr_pkg::MODE_DSLEEP: state_d = lpwr_pkg::ST_DSLEEP;
                        lpwr_pkg::MODE_PDOWN: state_d = lpwr_pkg::ST_PDOWN;
                        lpwr_pkg::MODE_DPD: state_d = lpwr_pkg::ST_DPD;
                        default: state_d = lpwr_pkg::ST_SLEEP;
                    endcase
                end
            end
            lpwr_pkg::ST_SLEEP, lpwr_pkg::ST_DSLEEP, lpwr_pkg::ST_PDOWN,
            lpwr_pkg::ST_DPD: begin
                if (wake) begin
                    state_d = lpwr_pkg::ST_RUN;
                end
            end
            default: state_d = lpwr_pkg::ST_RUN;
        endcase
    end

    // Self-wake timer counts down on REF_CLK while the low-power oscillator is powered
    always_comb begin
        wkt_cnt_d = wkt_cnt_q;
        if (we_wk) begin
            wkt_cnt_d = wv_wk[WKT_W-1:0];
        end else if (LPOSC_PWR & (wkt_cnt_q != '0)) begin
            wkt_cnt_d = wkt_cnt_q - WKT_W'(1);
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= lpwr_pkg::ST_RUN;
            wkt_cnt_q <= '0;
            wkt_flag_q <= 1'b0;
            refused_q <= 1'b0;
            cause_q <= '0;
            wake_rst_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wkt_cnt_q <= wkt_cnt_d;
            wkt_flag_q <= wkt_exp | (wkt_flag_q & ~we_wk);
            refused_q <= refuse | (refused_q & ~(we_st & AVS_WRITEDATA[lpwr_pkg::ST_REFUSED]
                & AVS_BYTEENABLE[0]));
            if (wake) begin
                cause_q <= hit;
            end
            wake_rst_q <= wake & rst_wake;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pwr_ctrl_q <= '0;
            dpd_ctrl_q <= '0;
            start_pin_q <= '0;
            start_per_q <= '0;
            fixed_pin_q <= 1'b0;
            sleep_cfg_q <= '0;
            bod_ctrl_q <= '0;
            wdt_mode_q <= '0;
            per_cfg_q <= '0;
            clk_cfg_q <= lpwr_pkg::CLK_CFG_RST;
        end else begin
            if (we_pc) pwr_ctrl_q <= wv_pc[2:0];
            if (wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_DPD_CTRL)) dpd_ctrl_q <= wv_dc[3:0];
            if (wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_START_PIN)) start_pin_q <= wv_sp[NPIN-1:0];
            if (wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_START_PER)) start_per_q <= wv_se[4:0];
            if (wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_FIXED_PIN)) fixed_pin_q <= wv_fp[0];
            if (wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_SLEEP_CFG)) sleep_cfg_q <= wv_sc[1:0];
            if (wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_BOD_CTRL)) bod_ctrl_q <= wv_bc[1:0];
            if (wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_WDT_MODE)) wdt_mode_q <= wv_wm[2:0];
            if (wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_PER_CFG)) per_cfg_q <= wv_pf[4:0];
            if (wake) begin
                clk_cfg_q[lpwr_pkg::CK_ALT] <= 1'b0;
            end else if (wr_acc & (AVS_ADDRESS == lpwr_pkg::OFS_CLK_CFG)) begin
                clk_cfg_q <= wv_ck[11:0];
            end
        end
    end

    // Clock and power gating per mode
    wire deep = in_dspd | in_dpd;
    wire pdn = (state_q == lpwr_pkg::ST_PDOWN) | in_dpd;
    assign CORE_CLK_EN = in_run;
    assign FRO_EN = deep ? ~pdn : clk_cfg_q[lpwr_pkg::CK_FRO];
    assign FLASH_EN = deep ? ~pdn : clk_cfg_q[lpwr_pkg::CK_FLASH];
    assign FRO_OUT_EN = ~deep & clk_cfg_q[lpwr_pkg::CK_FROOUT];
    assign PLL_EN = ~deep & clk_cfg_q[lpwr_pkg::CK_PLL];
    assign SYSTEM_OSC_EN = ~deep & clk_cfg_q[lpwr_pkg::CK_SYSTEM_OSC];
    assign ANALOG_EN = ~deep & clk_cfg_q[lpwr_pkg::CK_ANALOG];
    assign DIGITAL_EN = ~deep & clk_cfg_q[lpwr_pkg::CK_DIGITAL];
    assign BOD_PWR = ~in_dpd & clk_cfg_q[lpwr_pkg::CK_BOD];
    assign WATCHDOG_OSC_PWR = ~in_dpd & clk_cfg_q[lpwr_pkg::CK_WATCHDOG_OSC];
    assign TOUCH_PWR = ~in_dpd & clk_cfg_q[lpwr_pkg::CK_TOUCH];
    assign LPOSC_PWR = clk_cfg_q[lpwr_pkg::CK_LPOSC] & dpd_ctrl_q[lpwr_pkg::DC_LPOSC]
        & (~in_dpd | dpd_ctrl_q[lpwr_pkg::DC_LPKEEP]);
    assign CHIP_PWR = ~in_dpd;
    assign MAIN_CLK_ALT = in_run & clk_cfg_q[lpwr_pkg::CK_ALT] & ALT_CLK_STABLE;
    assign WAKE_RESET = wake_rst_q;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    a_dpd_lock_refuse: assert property (refuse |=> in_run && refused_q)
        else $error("Deep power-down entered while locked");
    a_dsleep_gating: assert property (state_q == lpwr_pkg::ST_DSLEEP |-> FRO_EN && FLASH_EN
        && !FRO_OUT_EN && !PLL_EN && !SYSTEM_OSC_EN && !ANALOG_EN && !DIGITAL_EN)
        else $error("Deep-sleep gating wrong");
    a_pdown_gating: assert property (pdn |-> !FRO_EN && !FLASH_EN)
        else $error("Power-down left oscillator or flash on");
    a_sleep_irq: assert property (in_sleep && |(IRQ_PENDING & IRQ_NESTED_INT_CTRL_EN)
        |=> in_run ##1 CORE_CLK_EN)
        else $error("Enabled interrupt did not wake sleep");
    a_no_wake_hold: assert property (in_dspd && !wake |=> $stable(state_q))
        else $error("Mode left without qualified wake");
    a_dpd_wake_pin: assert property (in_dpd && src[lpwr_pkg::WK_WPIN]
        |=> in_run && cause_q[lpwr_pkg::WK_WPIN] && WAKE_RESET)
        else $error("Wake pin exit wrong");
    a_dpd_power: assert property (in_dpd |-> !CHIP_PWR && !BOD_PWR && !WATCHDOG_OSC_PWR)
        else $error("Power left on in deep power-down");
    a_wkt_start: assert property (we_wk && !wkt_exp && wv_wk[WKT_W-1:0] > WKT_W'(1)
        |=> wkt_cnt_q != '0 && !wkt_flag_q)
        else $error("Wake timer not started by count write");
    a_fro_after_wake: assert property (!in_run ##1 in_run |-> !MAIN_CLK_ALT)
        else $error("Alternate clock kept after wake");
    a_bus_answer: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("Bus answer late");
    c_sleep_wake: cover property (in_sleep ##1 in_run);
    c_dpd_wake: cover property (in_dpd ##1 in_run);
    c_refused: cover property (refuse);
    c_wkt_wake: cover property (in_dspd && hit[lpwr_pkg::WK_WKT]);
endmodule // pwr_wake_ctrl

// ### bench/wake_src_model.sv
// Far-side model: external wake and reset pins plus on-chip wake sources.
// Assumes the bench picks one source and raises fire just after a clock edge.
`timescale 1ns/10ps
module wake_src_model (
    input wire logic fire,
    input wire logic [3:0] src,
    input wire logic [4:0] irq_sel,
    input wire logic [2:0] pin_sel,
    output logic [31:0] irq_pending,
    output logic [7:0] pin_int,
    output logic bod_int,
    output logic bod_rst,
    output logic wdt_int,
    output logic wdt_rst,
    output logic serial_int,
    output logic serial_ext_clk,
    output logic touch_event,
    output logic wake_pin_n,
    output logic reset_pin_n
);
    wire logic [10:0] hit = fire ? (11'h001 << src) : 11'h000;
    assign irq_pending = hit[lpwr_pkg::WK_IRQ] ? (32'h00000001 << irq_sel) : 32'h00000000;
    assign pin_int = hit[lpwr_pkg::WK_PIN] ? (8'h01 << pin_sel) : 8'h00;
    assign bod_int = hit[lpwr_pkg::WK_BODI];
    assign bod_rst = hit[lpwr_pkg::WK_BODR];
    assign wdt_int = hit[lpwr_pkg::WK_WDTI];
    assign wdt_rst = hit[lpwr_pkg::WK_WDTR];
    assign serial_int = hit[lpwr_pkg::WK_SER];
    assign serial_ext_clk = hit[lpwr_pkg::WK_SER];
    assign touch_event = hit[lpwr_pkg::WK_TCH];
    assign wake_pin_n = ~hit[lpwr_pkg::WK_WPIN];
    assign reset_pin_n = ~hit[lpwr_pkg::WK_RPIN];
endmodule // wake_src_model

// ### bench/tb.sv
// Self-checking bench for the power-mode and wake controller.
// Assumes the design and wake_src_model are compiled before it.
`timescale 1ns/10ps
module tb;
    logic ref_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, core_sleep_req = 0, fire = 0;
    logic [7:0] avs_address = 0, pin_nested_int_ctrl_en = 8'hFF;
    logic [31:0] avs_writedata = 0, irq_nested_int_ctrl_en = 32'hFFFFFFFF, rd, avs_readdata, irq_pending;
    logic [4:0] per_nested_int_ctrl_en = 5'h1F, irq_sel = 0;
    logic [3:0] src = 0;
    logic [2:0] pin_sel = 0;
    logic [7:0] pin_int;
    logic avs_waitrequest, bod_int, bod_rst, wdt_int, wdt_rst, serial_int, serial_ext_clk;
    logic touch_event, wake_pin_n, reset_pin_n, core_clk_en, fro_en, fro_out_en, flash_en;
    logic digital_en, chip_pwr, main_clk_alt, wake_reset;
    logic wdt_fed = 1, alt_stable = 1;
    int fail_count = 0, comparisons = 0, rst_seen = 0;
    wire logic [5:0] gate = {core_clk_en, fro_en, fro_out_en, flash_en, digital_en, chip_pwr};
    logic [7:0] cfg [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    // Mode, source, zeroed register (FF none, FE controller enables), wake, reset-type
    logic [15:0] cs [20] = '{
        {2'h0, 4'h0, 8'hFF, 2'b10},
        {2'h0, 4'h0, 8'hFE, 2'b00},
        {2'h1, 4'h2, 8'hFF, 2'b10},
        {2'h1, 4'h2, 8'h08, 2'b00},
        {2'h2, 4'h3, 8'h18, 2'b00},
        {2'h2, 4'h4, 8'hFF, 2'b11},
        {2'h1, 4'h5, 8'hFF, 2'b10},
        {2'h1, 4'h5, 8'h1C, 2'b00},
        {2'h2, 4'h6, 8'h14, 2'b00},
        {2'h1, 4'h8, 8'h20, 2'b00},
        {2'h2, 4'h9, 8'hFF, 2'b10},
        {2'h1, 4'h1, 8'h10, 2'b00},
        {2'h3, 4'hA, 8'hFF, 2'b11},
        {2'h3, 4'h1, 8'h04, 2'b00},
        {2'h1, 4'hA, 8'hFF, 2'b00},
        {2'h1, 4'h7, 8'hFF, 2'b10},
        {2'h3, 4'h7, 8'hFF, 2'b11},
        {2'h1, 4'h5, 8'hFD, 2'b00},
        {2'h0, 4'h1, 8'hFF, 2'b11},
        {2'h3, 4'h1, 8'hFF, 2'b11}
    };
    pwr_wake_ctrl #(.NIRQ(32), .NPIN(8), .WKT_W(32)) i_dut (
        .REF_CLK(ref_clk), .RESETN(resetn), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .CORE_SLEEP_REQ(core_sleep_req), .IRQ_PENDING(irq_pending), .IRQ_NESTED_INT_CTRL_EN(irq_nested_int_ctrl_en),
        .PIN_INT(pin_int), .PIN_NESTED_INT_CTRL_EN(pin_nested_int_ctrl_en), .PER_NESTED_INT_CTRL_EN(per_nested_int_ctrl_en),
        .BOD_INT(bod_int), .BOD_RST(bod_rst), .WDT_INT(wdt_int), .WDT_RST(wdt_rst),
        .WDT_FED(wdt_fed), .SERIAL_INT(serial_int), .SERIAL_EXT_CLK(serial_ext_clk),
        .TOUCH_EVENT(touch_event), .WAKE_PIN_N(wake_pin_n), .RESET_PIN_N(reset_pin_n),
        .ALT_CLK_STABLE(alt_stable), .CORE_CLK_EN(core_clk_en), .FRO_EN(fro_en),
        .FRO_OUT_EN(fro_out_en), .FLASH_EN(flash_en), .PLL_EN(), .SYSTEM_OSC_EN(), .ANALOG_EN(),
        .DIGITAL_EN(digital_en), .BOD_PWR(), .WATCHDOG_OSC_PWR(), .TOUCH_PWR(), .LPOSC_PWR(),
        .CHIP_PWR(chip_pwr), .MAIN_CLK_ALT(main_clk_alt), .WAKE_RESET(wake_reset)
    );
    wake_src_model i_src (
        .fire(fire), .src(src), .irq_sel(irq_sel), .pin_sel(pin_sel),
        .irq_pending(irq_pending), .pin_int(pin_int), .bod_int(bod_int), .bod_rst(bod_rst),
        .wdt_int(wdt_int), .wdt_rst(wdt_rst), .serial_int(serial_int),
        .serial_ext_clk(serial_ext_clk), .touch_event(touch_event),
        .wake_pin_n(wake_pin_n), .reset_pin_n(reset_pin_n)
    );
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (wake_reset === 1'b1) rst_seen++;
    end
    // Expected gating: core, fro, fro out, flash, digital, chip power
    function automatic logic [5:0] gexp(input logic [1:0] m);
        case (m)
            2'h0: return 6'h1F;
            2'h1: return 6'h15;
            2'h2: return 6'h01;
            default: return 6'h00;
        endcase
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        if (n >= 20) chk(32'h1, 32'h0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task do_reset();
        fire <= 1'b0;
        resetn <= 1'b0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
    endtask
    task enter();
        core_sleep_req <= 1'b1;
        @(posedge ref_clk);
        core_sleep_req <= 1'b0;
        @(posedge ref_clk);
    endtask
    task run_case(input logic [15:0] c);
        int n;
        do_reset();
        irq_nested_int_ctrl_en <= (c[9:2] == 8'hFE) ? 32'h00000000 : 32'hFFFFFFFF;
        wdt_fed <= (c[9:2] != 8'hFD);
        alt_stable <= 1'($urandom);
        foreach (cfg[i]) bus(1'b1, cfg[i], (cfg[i] == c[9:2]) ? 32'h0 : 32'hFF, rd);
        bus(1'b1, lpwr_pkg::OFS_CLK_CFG, 32'h00000C47, rd);
        chk(main_clk_alt, alt_stable);
        bus(1'b1, lpwr_pkg::OFS_PWR_CTRL, {30'h0, c[15:14]}, rd);
        rd = 32'h10 + $urandom % 8;
        if (c[13:10] == 4'h7) bus(1'b1, lpwr_pkg::OFS_WKT_COUNT, rd, rd);
        enter();
        chk(gate, gexp(c[15:14]));
        rst_seen = 0;
        fire <= 1'b1;
        src <= c[13:10];
        irq_sel <= 5'($urandom % 32);
        pin_sel <= 3'($urandom % 8);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (core_clk_en !== 1'b1 && n < 30);
        chk(n < 30, c[1]);
        fire <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(rst_seen != 0, c[0]);
        if (c[1]) begin
            chk(main_clk_alt, 1'b0);
            bus(1'b0, lpwr_pkg::OFS_STATUS, 32'h0, rd);
            chk(rd[2:0], 3'h0);
            chk(rd[lpwr_pkg::ST_CAUSE + c[13:10]], 1'b1);
        end else chk(gate, gexp(c[15:14]));
    endtask
    task conclude();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        conclude();
    end
    initial begin
        logic [31:0] r;
        r = $urandom(68);
        do_reset();
        chk(gate, 6'h3F);
        bus(1'b0, lpwr_pkg::OFS_STATUS, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b0, 8'h80, 32'h0, rd);
        chk(rd, 32'h0);
        r = $urandom & 32'hFF;
        bus(1'b1, lpwr_pkg::OFS_START_PIN, r, rd);
        bus(1'b0, lpwr_pkg::OFS_START_PIN, 32'h0, rd);
        chk(rd, r);
        bus(1'b1, lpwr_pkg::OFS_PWR_CTRL, 32'h7, rd);
        enter();
        chk(gate, 6'h3F);
        bus(1'b0, lpwr_pkg::OFS_STATUS, 32'h0, rd);
        chk(rd[lpwr_pkg::ST_REFUSED], 1'b1);
        foreach (cs[i]) run_case(cs[i]);
        conclude();
    end
endmodule // tb
